// [rtl/maint_step_pkg.sv]
// Purpose: Shared constants and types for the maintenance stepping controller.
// Assumes: One 100 MHz clock, synchronous active-high reset.
// Notes:   Command codes are four bits, processor numbers three bits.
package maint_step_pkg;
	localparam int CMD_W          = 4;
	localparam int PROC_N         = 8;
	localparam int PROC_W         = 3;
	localparam int BURST_W        = 8;
	localparam int CNT_W          = 9;
	localparam logic [3:0] CMD_NONE       = 4'h0;
	localparam logic [3:0] CMD_CYCLE_STEP = 4'hD;
	localparam logic [3:0] CMD_VP_BURST   = 4'hE;
	localparam logic [3:0] CMD_CONTINUOUS = 4'hF;
	localparam logic [1:0] MODE_MANUAL    = 2'h0;
	localparam logic [1:0] MODE_SEMI      = 2'h1;
	localparam logic [1:0] MODE_AUTO      = 2'h2;
	localparam logic [1:0] OVERRIDE_PHASE = 2'h3;
	localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
	localparam logic [PROC_N-1:0] FLAGS_CLEAR = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_EXECUTE = 3'b110,
		ST_ILLEGAL = 3'b111
	} ctrl_state_e;
endpackage : maint_step_pkg

// [rtl/burst_counter.sv]
// Purpose: Burst down-counter with a running indication.
// Assumes: Load value is already doubled by the caller.
// Notes:   Counts once on every clock while nonzero.
`timescale 1ns/100ps
`default_nettype none
module burst_counter
	import maint_step_pkg::*;
(
	// Clock and reset.
	input  wire logic                        core_clk,
	input  wire logic                        reset,
	// Control.
	input  wire logic                        burst_counter_load,
	input  wire logic [maint_step_pkg::CNT_W-1:0] load_value,
	// Status.
	output logic                             burst_counter_running,
	output logic [1:0]                       phase
);
	logic [CNT_W-1:0] count_q;

	always_ff @(posedge core_clk)
	begin
		if (reset)
			count_q <= CNT_ZERO;
		else if (burst_counter_load)
			count_q <= load_value;
		else if (count_q != CNT_ZERO)
			count_q <= count_q - 9'h001;
	end

	// Running stays high while the count is nonzero.
	assign burst_counter_running = (count_q != CNT_ZERO);
	assign phase                 = count_q[1:0];
endmodule // burst_counter
`default_nettype wire

// [rtl/advance_gate.sv]
// Purpose: Builds advance_pending and run_permit for the cycle step.
// Assumes: Test set and completion flags are per-processor.
// Notes:   One bit of logic per processor, from a generate loop.
`timescale 1ns/100ps
`default_nettype none
module advance_gate
	import maint_step_pkg::*;
(
	// Processor sets.
	input  wire logic [maint_step_pkg::PROC_N-1:0] under_test,
	input  wire logic [maint_step_pkg::PROC_N-1:0] cycle_complete_flags,
	input  wire logic [maint_step_pkg::PROC_W-1:0] current_proc,
	input  wire logic                              slot_zero,
	// Conditions.
	output logic                                   advance_pending,
	output logic                                   run_permit
);
	logic [PROC_N-1:0] open_vec;

	genvar i;
	generate
		for (i = 0; i < PROC_N; i++)
		begin : g_open
			assign open_vec[i] = under_test[i] & ~cycle_complete_flags[i];
		end
	endgenerate

	// Permit withdraws once the slot's processor has completed.
	assign run_permit      = ~under_test[current_proc] | open_vec[current_proc];
	// Pending drops once all are done and slot zero comes round.
	assign advance_pending = (|open_vec) | ~slot_zero;
endmodule // advance_gate
`default_nettype wire

// [rtl/maint_step_burst_control.sv]
// Purpose: Maintenance controller for cycle step, processor burst and continuous run.
// Assumes: Console strobes are synchronous to core_clk; mode and selector are static pins.
// Notes:   Outputs are registered; run control is a flop fed from next-cycle terms.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Cycle step sets busy, clears flags, executes.
// - Cycle run needs pending and permit both.
// - Permit withdraws run after processor completes.
// - Pending drops after last completion, slot zero.
// - Auto runs on, semi and manual stop.
// - Pending low ends cycle step, clears busy.
// - Processor burst legal only in manual mode.
// - Legal burst sets busy, loads doubled count.
// - Burst or continuous outside manual is illegal.
// - Counter runs each clock, run asserted.
// - Test processor advances every fourth clock.
// - Running low clears busy, returns idle.
// - Continuous runs until a new command.
// - Legal continuous sets busy, enters execute.
// - First continuous sets flag, clears, idles.
// - Repeat continuous clears flag, stops run.
// - Other command clears flag, then executes.
// - Running stays high while count nonzero.
module maint_step_burst_control
	import maint_step_pkg::*;
(
	// Clock and reset.
	input  wire logic                              core_clk,
	input  wire logic                              reset,
	// Command write from the register file.
	input  wire logic                              cmd_write,
	input  wire logic [maint_step_pkg::CMD_W-1:0]  cmd_code,
	input  wire logic [maint_step_pkg::BURST_W-1:0] burst_field,
	input  wire logic [maint_step_pkg::PROC_N-1:0] target_field,
	// Console and processor status.
	input  wire logic [1:0]                        mode,
	input  wire logic [maint_step_pkg::PROC_W-1:0] console_processor_selector,
	input  wire logic [maint_step_pkg::PROC_W-1:0] current_proc,
	input  wire logic                              slot_zero,
	input  wire logic [maint_step_pkg::PROC_N-1:0] instr_complete,
	// Register file status.
	output logic                                   busy_bit,
	output logic                                   illegal_bit,
	output logic [maint_step_pkg::CMD_W-1:0]       command_field,
	output logic [maint_step_pkg::PROC_N-1:0]      cycle_complete_flags,
	output logic [2:0]                             ctrl_state,
	// Run control.
	output logic                                   maintenance_run,
	output logic                                   test_advance,
	output logic                                   system_halt,
	output logic                                   continuous_run_flag
);
	ctrl_state_e          state_q;
	ctrl_state_e          state_d;
	logic [CMD_W-1:0]     cmd_q;
	logic                 busy_q;
	logic                 illegal_q;
	logic [PROC_N-1:0]    flags_q;
	logic [PROC_N-1:0]    test_set_q;
	logic                 cont_q;
	logic                 run_q;
	logic                 adv_q;
	logic                 halt_q;
	logic                 burst_counter_load;
	logic                 burst_counter_running;
	logic [1:0]           phase;
	logic                 advance_pending;
	logic                 run_permit;
	logic                 manual;
	logic                 accept;
	logic                 illegal_now;
	logic                 cycle_run;
	logic                 burst_run;
	logic                 cont_run;
	logic                 done_exec;

	assign manual      = (mode == MODE_MANUAL);
	assign accept      = cmd_write & (state_q == ST_IDLE);
	assign illegal_now = ~manual & ((cmd_code == CMD_VP_BURST) | (cmd_code == CMD_CONTINUOUS));

	burst_counter u_burst (
		.core_clk              (core_clk),
		.reset                 (reset),
		.burst_counter_load    (burst_counter_load),
		.load_value            ({burst_field, 1'b0}),
		.burst_counter_running (burst_counter_running),
		.phase                 (phase)
	);

	advance_gate u_gate (
		.under_test           (test_set_q),
		.cycle_complete_flags (flags_q),
		.current_proc         (current_proc),
		.slot_zero            (slot_zero),
		.advance_pending      (advance_pending),
		.run_permit           (run_permit)
	);

	// Doubled burst field loads on a legal burst command.
	assign burst_counter_load = accept & (cmd_code == CMD_VP_BURST) & manual;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
			begin
				if (accept)
				begin
					if (illegal_now)
						state_d = ST_ILLEGAL;
					else if ((cmd_code == CMD_CYCLE_STEP) | (cmd_code == CMD_VP_BURST))
						state_d = ST_EXECUTE;
					else if (cmd_code == CMD_CONTINUOUS)
						state_d = ST_EXECUTE;
				end
			end
			ST_EXECUTE:
			begin
				if (done_exec)
					state_d = ST_IDLE;
			end
			ST_ILLEGAL:
			begin
				if (manual)
					state_d = ST_IDLE;
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_comb
	begin
		case (cmd_q)
			CMD_CYCLE_STEP: done_exec = ~advance_pending;
			CMD_VP_BURST:   done_exec = ~burst_counter_running & ~burst_counter_load;
			default:        done_exec = 1'b1;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// Command field latches on accept and clears when the command ends.
	always_ff @(posedge core_clk)
	begin
		if (reset)
			cmd_q <= CMD_NONE;
		else if (accept)
			cmd_q <= cmd_code;
		else if ((state_q != ST_IDLE) & (state_d == ST_IDLE))
			cmd_q <= CMD_NONE;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			busy_q <= 1'b0;
		else if (accept & (state_d != ST_IDLE))
			busy_q <= 1'b1;
		else if ((state_q != ST_IDLE) & (state_d == ST_IDLE))
			busy_q <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			illegal_q <= 1'b0;
		else if (accept & illegal_now)
			illegal_q <= 1'b1;
		else if ((state_q == ST_ILLEGAL) & manual)
			illegal_q <= 1'b0;
	end

	// Completion flags clear on a cycle step, then set as processors finish.
	// A completion that falls in the clearing cycle still lands, so set wins.
	always_ff @(posedge core_clk)
	begin
		if (reset)
			flags_q <= FLAGS_CLEAR;
		else if (accept & (cmd_code == CMD_CYCLE_STEP))
			flags_q <= FLAGS_CLEAR | instr_complete;
		else
			flags_q <= flags_q | instr_complete;
	end

	// Processors under test: the target field, or the selector alone in manual.
	always_ff @(posedge core_clk)
	begin
		if (reset)
			test_set_q <= FLAGS_CLEAR;
		else if (accept & manual)
			test_set_q <= 8'h01 << console_processor_selector;
		else if (accept)
			test_set_q <= target_field;
	end

	// Continuous flag toggles on legal continuous commands; others clear it.
	always_ff @(posedge core_clk)
	begin
		if (reset)
			cont_q <= 1'b0;
		else if ((state_q == ST_EXECUTE) & (cmd_q == CMD_CONTINUOUS))
			cont_q <= ~cont_q;
		else if (accept & (cmd_code != CMD_CONTINUOUS))
			cont_q <= 1'b0;
	end

	assign cycle_run = (state_d == ST_EXECUTE) & (cmd_q == CMD_CYCLE_STEP)
		& advance_pending & run_permit;
	assign burst_run = (state_q == ST_EXECUTE) & (cmd_q == CMD_VP_BURST)
		& burst_counter_running;
	assign cont_run  = cont_q & ~(accept & (cmd_code != CMD_CONTINUOUS));

	always_ff @(posedge core_clk)
	begin
		if (reset)
			run_q <= 1'b0;
		else
			run_q <= cycle_run | burst_run | cont_run;
	end

	// Test processor steps only on every fourth clock during a burst.
	always_ff @(posedge core_clk)
	begin
		if (reset)
			adv_q <= 1'b0;
		else if (burst_run)
			adv_q <= (phase == OVERRIDE_PHASE);
		else
			adv_q <= cycle_run | cont_run;
	end

	// After a cycle step auto keeps running; semi and manual stop.
	always_ff @(posedge core_clk)
	begin
		if (reset)
			halt_q <= 1'b0;
		else if (accept)
			halt_q <= 1'b0;
		else if ((state_q == ST_EXECUTE) & (cmd_q == CMD_CYCLE_STEP) & done_exec)
			halt_q <= (mode != MODE_AUTO);
	end

	assign busy_bit             = busy_q;
	assign illegal_bit          = illegal_q;
	assign command_field        = cmd_q;
	assign cycle_complete_flags = flags_q;
	assign ctrl_state           = state_q;
	assign maintenance_run      = run_q;
	assign test_advance         = adv_q;
	assign system_halt          = halt_q;
	assign continuous_run_flag  = cont_q;
endmodule // maint_step_burst_control
`default_nettype wire

// [dv/maint_step_props.sv]
// Purpose: Checker for the maintenance stepping controller.
// Assumes: Sees only the ports of the controller.
// Notes:   Bound to every controller instance.
`timescale 1ns/100ps
`default_nettype none
module maint_step_props
	import maint_step_pkg::*;
(
	// Clock, reset and inputs.
	input wire logic       core_clk,
	input wire logic       reset,
	input wire logic       cmd_write,
	input wire logic [3:0] cmd_code,
	input wire logic [7:0] burst_field,
	input wire logic [7:0] target_field,
	input wire logic [1:0] mode,
	input wire logic [2:0] console_processor_selector,
	input wire logic [2:0] current_proc,
	input wire logic       slot_zero,
	input wire logic [7:0] instr_complete,
	// Outputs.
	input wire logic       busy_bit,
	input wire logic       illegal_bit,
	input wire logic [3:0] command_field,
	input wire logic [7:0] cycle_complete_flags,
	input wire logic [2:0] ctrl_state,
	input wire logic       maintenance_run,
	input wire logic       test_advance,
	input wire logic       system_halt,
	input wire logic       continuous_run_flag
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);
	wire logic idle_wr;
	wire logic legal;
	wire logic bad;
	assign idle_wr = cmd_write && ctrl_state == 3'b000;
	assign legal = cmd_code == CMD_CYCLE_STEP || cmd_code > CMD_CYCLE_STEP && mode == MODE_MANUAL;
	assign bad = cmd_code > CMD_CYCLE_STEP && mode != MODE_MANUAL;
	sequence cont_accept;
		idle_wr && cmd_code == CMD_CONTINUOUS && mode == MODE_MANUAL && !continuous_run_flag;
	endsequence
	sequence cont_settle;
		ctrl_state == 3'b110 ##1 ctrl_state == 3'b000 && continuous_run_flag && !busy_bit;
	endsequence
	sequence cycle_end;
		ctrl_state == 3'b110 && command_field == CMD_CYCLE_STEP ##1 ctrl_state == 3'b000;
	endsequence
	a_flags_clear: assert property (idle_wr && cmd_code == CMD_CYCLE_STEP |=>
		cycle_complete_flags == $past(instr_complete)) else $error("flags not cleared");
	a_cycle_hold: assert property (ctrl_state == 3'b110 && command_field == CMD_CYCLE_STEP
		&& !slot_zero |=> ctrl_state == 3'b110) else $error("cycle step ended off slot zero");
	a_cycle_halt: assert property (cycle_end |-> system_halt == (mode != MODE_AUTO))
		else $error("halt after cycle step wrong");
	a_cycle_stop: assert property (cycle_end |-> !maintenance_run)
		else $error("run after cycle step");
	a_legal_accept: assert property (idle_wr && legal |=> busy_bit && ctrl_state == 3'b110)
		else $error("legal command not entered");
	a_illegal_entry: assert property (idle_wr && bad |=>
		ctrl_state == 3'b111 && illegal_bit && busy_bit) else $error("illegal entry wrong");
	a_illegal_exit: assert property (ctrl_state == 3'b111 && mode == MODE_MANUAL |=>
		ctrl_state == 3'b000 && !illegal_bit && !busy_bit && command_field == CMD_NONE)
		else $error("illegal exit wrong");
	a_idle_quiet: assert property (ctrl_state == 3'b000 |-> !busy_bit && !illegal_bit)
		else $error("busy while idle");
	a_field_capture: assert property (idle_wr && cmd_code >= CMD_CYCLE_STEP |=>
		command_field == $past(cmd_code)) else $error("command field not captured");
	a_cont_first: assert property (cont_accept |=> cont_settle)
		else $error("continuous start wrong");
	a_cont_clear: assert property (continuous_run_flag && idle_wr && legal &&
		cmd_code != CMD_CONTINUOUS |=> !continuous_run_flag) else $error("flag not cleared");
	a_burst_gap: assert property (test_advance && command_field == CMD_VP_BURST |=>
		!test_advance [*3]) else $error("burst advance too often");
endmodule // maint_step_props
bind maint_step_burst_control maint_step_props props_u (.core_clk(core_clk), .reset(reset),
	.cmd_write(cmd_write), .cmd_code(cmd_code), .burst_field(burst_field),
	.target_field(target_field), .mode(mode), .current_proc(current_proc),
	.console_processor_selector(console_processor_selector), .slot_zero(slot_zero),
	.instr_complete(instr_complete), .busy_bit(busy_bit), .illegal_bit(illegal_bit),
	.command_field(command_field), .cycle_complete_flags(cycle_complete_flags),
	.ctrl_state(ctrl_state), .maintenance_run(maintenance_run), .test_advance(test_advance),
	.system_halt(system_halt), .continuous_run_flag(continuous_run_flag));
`default_nettype wire

// [dv/slot_model.sv]
// Purpose: Time slot and instruction completion model of the processors.
// Assumes: Processors finish an instruction after four run cycles.
// Notes:   Outputs change on the falling edge.
`timescale 1ns/100ps
`default_nettype none
module slot_model
(
	// Clock and reset.
	input  wire logic       core_clk,
	input  wire logic       reset,
	// Run control.
	input  wire logic       maintenance_run,
	// Time slot and completion.
	output logic [2:0]      current_proc,
	output logic            slot_zero,
	output logic [7:0]      instr_complete
);
	logic [1:0] run_cnt_q;
	assign slot_zero = current_proc == 3'h0;
	always_ff @(negedge core_clk)
	begin
		if (reset)
		begin
			current_proc   <= 3'h0;
			run_cnt_q      <= 2'h0;
			instr_complete <= 8'h00;
		end
		else
		begin
			current_proc   <= current_proc + 3'h1;
			run_cnt_q      <= maintenance_run ? run_cnt_q + 2'h1 : run_cnt_q;
			instr_complete <= (maintenance_run && run_cnt_q == 2'h3) ? 8'hFF : 8'h00;
		end
	end
endmodule // slot_model
`default_nettype wire

// [dv/maint_step_burst_control_tb.sv]
// Purpose: Self-checking bench of the maintenance stepping controller.
// Assumes: Inputs change on the falling edge.
// Notes:   Commands are issued by the wr task.
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
	$display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module maint_step_burst_control_tb;
	import maint_step_pkg::*;
	logic       core_clk = 1'b0;
	logic       reset, cmd_write, slot_zero, maintenance_run, test_advance;
	logic       busy_bit, illegal_bit, system_halt, continuous_run_flag, run_seen;
	logic [3:0] cmd_code, command_field;
	logic [7:0] burst_field, target_field, instr_complete, cycle_complete_flags;
	logic [1:0] mode;
	logic [2:0] sel, current_proc, ctrl_state;
	int         errors = 0, samples_checked = 0, adv_cnt = 0;
	always #5 core_clk = ~core_clk;
	maint_step_burst_control dut_u (.core_clk(core_clk), .reset(reset), .cmd_write(cmd_write),
		.cmd_code(cmd_code), .burst_field(burst_field), .target_field(target_field),
		.mode(mode), .console_processor_selector(sel), .current_proc(current_proc),
		.slot_zero(slot_zero), .instr_complete(instr_complete), .busy_bit(busy_bit),
		.illegal_bit(illegal_bit), .command_field(command_field), .ctrl_state(ctrl_state),
		.cycle_complete_flags(cycle_complete_flags), .maintenance_run(maintenance_run),
		.test_advance(test_advance), .system_halt(system_halt),
		.continuous_run_flag(continuous_run_flag));
	slot_model model_u (.core_clk(core_clk), .reset(reset), .maintenance_run(maintenance_run),
		.current_proc(current_proc), .slot_zero(slot_zero), .instr_complete(instr_complete));
	always @(posedge core_clk)
	begin
		if (test_advance === 1'b1) adv_cnt++;
		if (maintenance_run === 1'b1) run_seen = 1'b1;
	end
	task automatic step(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic wr(input logic [3:0] c, input logic [7:0] b);
		@(negedge core_clk);
		cmd_code = c;
		burst_field = b;
		cmd_write = 1'b1;
		@(negedge core_clk);
		cmd_write = 1'b0;
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (ctrl_state !== 3'b000 && n < 600)
		begin
			@(negedge core_clk);
			n++;
		end
		`CHECK("idle wait", 1'b1, n < 600)
	endtask
	task automatic summarize();
		$display("checked %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		#300000;
		errors++;
		summarize();
	end
	initial
	begin
		{reset, cmd_write, cmd_code, burst_field, run_seen} = {1'b1, 1'b0, 4'h0, 8'h00, 1'b0};
		{mode, sel, target_field} = {MODE_MANUAL, 3'h2, 8'h05};
		step(16);
		reset = 1'b0;
		`CHECK("reset busy", 1'b0, busy_bit)
		`CHECK("reset state", 3'b000, ctrl_state)
		for (int m = 0; m < 3; m++)
		begin
			mode = 2'(m);
			run_seen = 1'b0;
			wr(CMD_CYCLE_STEP, 8'h00);
			`CHECK("cycle state", 3'b110, ctrl_state)
			`CHECK("cycle busy", 1'b1, busy_bit)
			`CHECK("cycle flags", FLAGS_CLEAR, cycle_complete_flags)
			wait_idle();
			step(2);
			`CHECK("cycle run", 1'b1, run_seen)
			`CHECK("cycle field", CMD_NONE, command_field)
			`CHECK("cycle halt", m != 2, system_halt)
		end
		mode = MODE_MANUAL;
		adv_cnt = 0;
		run_seen = 1'b0;
		wr(CMD_VP_BURST, 8'h08);
		`CHECK("burst state", 3'b110, ctrl_state)
		`CHECK("burst busy", 1'b1, busy_bit)
		step(4);
		`CHECK("burst running", 1'b1, maintenance_run)
		wait_idle();
		`CHECK("burst run", 1'b1, run_seen)
		`CHECK("burst steps", 4, adv_cnt)
		`CHECK("burst field", CMD_NONE, command_field)
		for (int i = 0; i < 4; i++)
		begin
			mode = i[1] ? MODE_AUTO : MODE_SEMI;
			wr(i[0] ? CMD_CONTINUOUS : CMD_VP_BURST, 8'h04);
			`CHECK("illegal state", 3'b111, ctrl_state)
			`CHECK("illegal bit", 1'b1, illegal_bit)
			wr(CMD_CYCLE_STEP, 8'h00);
			`CHECK("illegal hold", 3'b111, ctrl_state)
			mode = MODE_MANUAL;
			step(2);
			`CHECK("illegal exit", 3'b000, ctrl_state)
			`CHECK("illegal clear", 1'b0, illegal_bit)
		end
		wr(CMD_CONTINUOUS, 8'h00);
		`CHECK("cont state", 3'b110, ctrl_state)
		`CHECK("cont enter busy", 1'b1, busy_bit)
		wait_idle();
		`CHECK("cont flag", 1'b1, continuous_run_flag)
		`CHECK("cont busy", 1'b0, busy_bit)
		step(3);
		`CHECK("cont run", 1'b1, maintenance_run)
		wr(CMD_CONTINUOUS, 8'h00);
		wait_idle();
		step(2);
		`CHECK("cont stop", 1'b0, continuous_run_flag)
		wr(CMD_CONTINUOUS, 8'h00);
		wait_idle();
		wr(CMD_VP_BURST, 8'h02);
		`CHECK("cont cleared", 1'b0, continuous_run_flag)
		`CHECK("next state", 3'b110, ctrl_state)
		wait_idle();
		summarize();
	end
endmodule // maint_step_burst_control_tb
`default_nettype wire
